// *** hdl/twrs_defs.svh ***
// constants for the two-wire register access slave
// assumes inclusion by bare name from any design file
`ifndef TWRS_DEFS_SVH
`define TWRS_DEFS_SVH

`define TWRS_ADDR_SEL_LOW  7'h48
`define TWRS_ADDR_SEL_HIGH 7'h5d
`define TWRS_REG_ADDR_RST  16'h0000
`define TWRS_BIT_LAST      3'h7
`define TWRS_BIT_FIRST     3'h0
`define TWRS_ADDR_STEP     16'h0001

`endif

// *** hdl/twrs_pkg.sv ***
// types of the two-wire register access slave
// assumes no surroundings beyond the compile order
package twrs_pkg;
  // gray codes along the address, reg-high, reg-low, data path
  typedef enum logic [2:0] {
    twrs_idle_type_s   = 3'h0,
    twrs_devaddr_s     = 3'h1,
    twrs_reg_hi_s      = 3'h3,
    twrs_reg_lo_s      = 3'h2,
    twrs_wr_data_s     = 3'h6,
    twrs_rd_data_s     = 3'h7,
    twrs_rd_ack_s      = 3'h5,
    twrs_ignore_s      = 3'h4
  } twrs_state_type;
endpackage

// *** hdl/twrs_sync.sv ***
// two-flop synchroniser with edge flags for the bus pins
// assumes asynchronous pin levels and a single core clock
module twrs_sync (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic sync;
  logic prev;

  // first flop is read only by the second
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pin_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;
  assign fall  = ~sync & prev;
endmodule

// *** hdl/twrs_slave.sv ***
// two-wire register access slave: byte engine and register address
// assumes serial clock much slower than core_clk (40 MHz), external
// register store answering rd_data combinationally per address
`include "twrs_defs.svh"
module twrs_slave (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_sel,
  output logic             wr_strobe,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic [15:0]      rd_addr,
  input  wire logic [7:0]  rd_data,
  output logic             busy
);
  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic sda_rise;
  logic sda_fall;
  logic sel_sync;

  twrs_sync scl_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (scl_in),
    .level    (scl),
    .rise     (scl_rise),
    .fall     (scl_fall)
  );
  twrs_sync sda_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (sda_in),
    .level    (sda),
    .rise     (sda_rise),
    .fall     (sda_fall)
  );
  twrs_sync sel_sync_i (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (addr_sel),
    .level    (sel_sync),
    .rise     (),
    .fall     ()
  );

  // start and stop only while the clock line is high
  logic start_cond;
  logic stop_cond;
  assign start_cond = sda_fall & scl;
  assign stop_cond  = sda_rise & scl;

  // ***************************************************************
  // byte engine
  // ***************************************************************
  twrs_pkg::twrs_state_type state;
  twrs_pkg::twrs_state_type next_state;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic        ack_phase;
  logic        next_ack_phase;
  logic        drive_low;
  logic        next_drive_low;
  logic        drive_en;
  logic        next_drive_en;
  logic [15:0] reg_addr;
  logic [15:0] next_reg_addr;
  logic [7:0]  addr_hi;
  logic [7:0]  next_addr_hi;
  logic        strobe;
  logic        next_strobe;
  logic [15:0] wa;
  logic [15:0] next_wa;
  logic [7:0]  wd;
  logic [7:0]  next_wd;
  logic [7:0]  next_byte;
  logic        addr_match;

  assign next_byte = {shreg[6:0], sda};
  // address select picks one of two 7-bit slave addresses
  assign addr_match = (next_byte[7:1] == (sel_sync ? `TWRS_ADDR_SEL_HIGH
                                                  : `TWRS_ADDR_SEL_LOW));

  // next-state logic: bits taken on clock rise, data driven on fall
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_ack_phase = ack_phase;
    next_drive_low = drive_low;
    next_drive_en  = drive_en;
    next_reg_addr  = reg_addr;
    next_addr_hi   = addr_hi;
    next_strobe    = 1'b0;
    next_wa        = wa;
    next_wd        = wd;
    if (stop_cond) begin
      // address held across stop for current-location reads
      next_state    = twrs_pkg::twrs_idle_type_s;
      next_drive_en = 1'b0;
      next_ack_phase = 1'b0;
    end else if (start_cond) begin
      // a restart keeps the loaded address for the read that follows
      next_state     = twrs_pkg::twrs_devaddr_s;
      next_bit_cnt   = `TWRS_BIT_FIRST;
      next_ack_phase = 1'b0;
      next_drive_en  = 1'b0;
    end else if (scl_rise && !ack_phase) begin
      case (state)
        twrs_pkg::twrs_devaddr_s,
        twrs_pkg::twrs_reg_hi_s,
        twrs_pkg::twrs_reg_lo_s,
        twrs_pkg::twrs_wr_data_s: begin
          next_shreg   = next_byte;
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == `TWRS_BIT_LAST) begin
            next_ack_phase = 1'b1;
            next_drive_low = 1'b1;
            case (state)
              twrs_pkg::twrs_devaddr_s: begin
                if (!addr_match) begin
                  next_state     = twrs_pkg::twrs_ignore_s;
                  next_ack_phase = 1'b0;
                end else if (next_byte[0]) begin
                  // read with no address phase uses current address
                  next_state = twrs_pkg::twrs_rd_data_s;
                end else begin
                  next_state = twrs_pkg::twrs_reg_hi_s;
                end
              end
              twrs_pkg::twrs_reg_hi_s: begin
                next_addr_hi = next_byte;
                next_state   = twrs_pkg::twrs_reg_lo_s;
              end
              twrs_pkg::twrs_reg_lo_s: begin
                next_reg_addr = {addr_hi, next_byte};
                next_state    = twrs_pkg::twrs_wr_data_s;
              end
              default: begin
                // store then step the address per byte
                next_strobe   = 1'b1;
                next_wa       = reg_addr;
                next_wd       = next_byte;
                next_reg_addr = reg_addr + `TWRS_ADDR_STEP;
              end
            endcase
          end
        end
        twrs_pkg::twrs_rd_data_s: begin
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == `TWRS_BIT_LAST) begin
            next_ack_phase = 1'b1;
            next_state     = twrs_pkg::twrs_rd_ack_s;
            next_reg_addr  = reg_addr + `TWRS_ADDR_STEP;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_rise && ack_phase &&
                 state == twrs_pkg::twrs_rd_ack_s) begin
      // master ack keeps the read going, nack ends it
      next_ack_phase = 1'b0;
      next_state = sda ? twrs_pkg::twrs_ignore_s
                       : twrs_pkg::twrs_rd_data_s;
    end else if (scl_fall) begin
      if (state == twrs_pkg::twrs_rd_ack_s) begin
        // master owns this slot; ack_phase stays up until its clock rise
        next_drive_en = 1'b0;
      end else if (ack_phase && !drive_en) begin
        next_drive_en = drive_low;
      end else if (ack_phase && drive_en) begin
        // ack period over; release or start a read byte
        next_ack_phase = 1'b0;
        next_drive_en  = 1'b0;
        next_drive_low = 1'b0;
        if (state == twrs_pkg::twrs_rd_data_s) begin
          next_shreg    = {rd_data[6:0], 1'b0};
          next_drive_en = ~rd_data[7];
        end
      end else if (state == twrs_pkg::twrs_rd_data_s) begin
        if (bit_cnt == `TWRS_BIT_FIRST) begin
          next_shreg    = {rd_data[6:0], 1'b0};
          next_drive_en = ~rd_data[7];
        end else begin
          next_shreg    = {shreg[6:0], 1'b0};
          next_drive_en = ~shreg[7];
        end
      end else begin
        // release the line while the master sends its bits
        next_drive_en = 1'b0;
      end
    end
  end

  // registers of the byte engine
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state     <= twrs_pkg::twrs_idle_type_s;
      bit_cnt   <= `TWRS_BIT_FIRST;
      shreg     <= 8'h00;
      ack_phase <= 1'b0;
      drive_low <= 1'b0;
      drive_en  <= 1'b0;
      reg_addr  <= `TWRS_REG_ADDR_RST;
      addr_hi   <= 8'h00;
      strobe    <= 1'b0;
      wa        <= `TWRS_REG_ADDR_RST;
      wd        <= 8'h00;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      ack_phase <= next_ack_phase;
      drive_low <= next_drive_low;
      drive_en  <= next_drive_en;
      reg_addr  <= next_reg_addr;
      addr_hi   <= next_addr_hi;
      strobe    <= next_strobe;
      wa        <= next_wa;
      wd        <= next_wd;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // open drain: only ever pulls low
  assign sda_out   = 1'b0;
  assign sda_oe    = drive_en;
  assign wr_strobe = strobe;
  assign wr_addr   = wa;
  assign wr_data   = wd;
  assign rd_addr   = reg_addr;
  assign busy      = (state != twrs_pkg::twrs_idle_type_s);
endmodule

// *** tb/twrs_slave_asserts.sv ***
// checker for the slave byte engine and its address counter
// assumes binding to twrs_slave, one core_clk domain
module twrs_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        addr_sel,
  input wire logic        wr_strobe,
  input wire logic [15:0] wr_addr,
  input wire logic [7:0]  wr_data,
  input wire logic [15:0] rd_addr,
  input wire logic [7:0]  rd_data,
  input wire logic        busy
);
  // ****************************************
  // properties, all on core_clk
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  strobe_one_cycle_a: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  strobe_in_frame_a: assert property (wr_strobe |-> busy)
    else $error("write strobe outside a transfer");
  addr_steps_a: assert property
    (wr_strobe |-> ##[0:2] (rd_addr == wr_addr + 16'h0001))
    else $error("address did not step after write byte");
  addr_kept_idle_a: assert property
    (!busy && !$past(busy) |-> $stable(rd_addr))
    else $error("address moved while idle");
  idle_released_a: assert property
    (!busy && !$past(busy) |-> !sda_oe)
    else $error("data line driven while idle");
  oe_steady_high_a: assert property
    (scl_in [*6] |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  open_drain_a: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  start_seen_a: assert property
    ($rose(busy) |-> scl_in && !sda_in)
    else $error("transfer began without a start");
  cover property (wr_strobe);
  cover property ($rose(sda_oe));
  cover property ($fell(busy));
endmodule

bind twrs_slave twrs_chk i_chk (.core_clk, .reset, .scl_in, .sda_in,
  .sda_out, .sda_oe, .addr_sel, .wr_strobe, .wr_addr, .wr_data, .rd_addr,
  .rd_data, .busy);

// *** tb/twrs_host_model.sv ***
// host bus master: start, stop, restart and nine-bit slots
// assumes a pulled-up data line resolved by the testbench
module twrs_host_model (
  input  wire logic core_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter bit, kept above the slave's 4-clock minimum
  localparam int QTR = 6;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // hold both pins for one quarter bit
  task automatic step(input logic c, input logic d);
    @(posedge core_clk);
    scl     <= c;
    sda_low <= d;
    repeat (QTR - 1) @(posedge core_clk);
  endtask
  // release data while clock low, so this also serves as restart
  task automatic start();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  // clock then stands high until the next frame
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // msb first; tx bit 1 releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, !tx[i]);
      step(1'b1, !tx[i]);
      rx[i] = sda_line;
      step(1'b1, !tx[i]);
      step(1'b0, !tx[i]);
    end
  endtask
endmodule

// *** tb/twrs_slave_tb_top.sv ***
// testbench: slave, host model and a byte store behind the slave
// assumes the host model is the only master on the bus
module twrs_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        addr_sel = 1'b0;
  logic        scl, host_low, sda_out, sda_oe, wr_strobe, busy;
  logic [15:0] wr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data;
  logic [7:0]  store [0:65535];
  logic [8:0]  r;
  int          mismatches = 0;
  int          checks_done = 0;
  // pulled-up line, low when either party pulls
  wire         sda_line = !(host_low || (sda_oe && !sda_out));
  always #12.5 core_clk = ~core_clk;
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  initial begin
    for (int i = 0; i < 65536; i++) store[i] = pat(16'(i));
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
  end
  always @(posedge core_clk) if (wr_strobe) store[wr_addr] <= wr_data;
  assign rd_data = store[rd_addr];
  twrs_slave i_dut (.core_clk, .reset, .scl_in(scl), .sda_in(sda_line),
    .sda_out, .sda_oe, .addr_sel, .wr_strobe, .wr_addr, .wr_data,
    .rd_addr, .rd_data, .busy);
  twrs_host_model i_host (.core_clk, .sda_line, .scl, .sda_low(host_low));
  // ****************************************
  // compare helpers
  // ****************************************
  task automatic chk_ack(input string what, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_val(input string what, input logic [15:0] e,
                         input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] b);
    i_host.xfer({b, 1'b1}, r);
    chk_ack("ack", 1'b0, r[0]);
  endtask
  task automatic rd(input logic [15:0] a, input logic last);
    i_host.xfer({8'hff, last}, r);
    chk_val("read byte", {8'h00, pat(a)}, {8'h00, r[8:1]});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_write();
    i_host.start();
    chk_ack("busy after start", 1'b1, busy);
    wr(8'h90);
    wr(8'h12);
    wr(8'h34);
    wr(8'hab);
    wr(8'hcd);
    i_host.stop();
    chk_ack("busy after stop", 1'b0, busy);
    chk_val("byte 1234", 16'h00ab, {8'h00, store[16'h1234]});
    chk_val("byte 1235", 16'h00cd, {8'h00, store[16'h1235]});
    chk_val("rd_addr", 16'h1236, rd_addr);
    $display("test write done");
  endtask
  task automatic t_reads();
    i_host.start();
    wr(8'h90);
    wr(8'h20);
    wr(8'h00);
    i_host.start();
    wr(8'h91);
    rd(16'h2000, 1'b0);
    rd(16'h2001, 1'b0);
    rd(16'h2002, 1'b1);
    i_host.stop();
    i_host.start();
    wr(8'h91);
    rd(16'h2003, 1'b1);
    i_host.stop();
    chk_val("rd_addr", 16'h2004, rd_addr);
    $display("test reads done");
  endtask
  task automatic t_select();
    @(posedge core_clk);
    addr_sel <= 1'b1;
    i_host.start();
    i_host.xfer({8'h90, 1'b1}, r);
    chk_ack("refused", 1'b1, r[0]);
    i_host.stop();
    i_host.start();
    wr(8'hba);
    wr(8'h00);
    wr(8'h10);
    wr(8'h77);
    i_host.stop();
    chk_val("byte 0010", 16'h0077, {8'h00, store[16'h0010]});
    i_host.start();
    wr(8'hbb);
    rd(16'h0011, 1'b1);
    i_host.stop();
    $display("test select done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    t_write();
    t_reads();
    t_select();
    tally_and_finish();
  end
  // cut a hang well past the ~4800 cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
